// ==== cpcvr_pkg.sv ====
package cpcvr_pkg;

   // ---------------------------------------------------------------
   // Register map
   // ---------------------------------------------------------------
   localparam int ADDR_W = 8;
   localparam int DATA_W = 16;
   localparam logic [7:0] PWR_CLK_CTRL_OFFS = 8'h04;
   localparam logic [7:0] MASTER_VOL_OFFS = 8'h10;
   localparam logic [7:0] MIXER_VOL_OFFS = 8'h11;

   // ---------------------------------------------------------------
   // Power and clock control fields
   // ---------------------------------------------------------------
   localparam int DAC_PWR_BIT = 15;
   localparam int ADC_L_PWR_BIT = 10;
   localparam int ADC_R_PWR_BIT = 9;
   localparam int ADC_BIAS_BIT = 8;
   localparam int DAC_CLK_EN_BIT = 7;
   localparam int DAC_CLK_AUTO_BIT = 6;
   localparam int DEC_CLK_EN_BIT = 2;
   localparam int INT_CLK_EN_BIT = 0;
   localparam logic [15:0] PWR_CLK_RESET = 16'h8705;
   localparam logic [15:0] PWR_CLK_MASK = 16'h87C5;

   // ---------------------------------------------------------------
   // Volume fields
   // ---------------------------------------------------------------
   localparam int VOL_W = 8;
   localparam int HI_LSB = 8;
   localparam logic [15:0] MASTER_VOL_RESET = 16'h0000;
   localparam logic [15:0] MIXER_VOL_RESET = 16'hFF00;
   localparam int NUM_VOL_CH = 4;

   // Attenuation in quarter dB steps
   localparam int ATT_W = 9;
   localparam logic [8:0] COARSE_STEP_QDB = 9'h008;
   localparam logic [7:0] MASTER_FINE_END = 8'hD0;
   localparam logic [5:0] MASTER_FINE_QUAD = 6'h34;
   localparam logic [5:0] MASTER_COARSE_LAST = 6'h3B;
   localparam logic [5:0] MASTER_Q_69 = 6'h3C;
   localparam logic [5:0] MASTER_Q_72 = 6'h3D;
   localparam logic [5:0] MASTER_Q_78 = 6'h3E;
   localparam logic [8:0] ATT_69_QDB = 9'h114;
   localparam logic [8:0] ATT_72_QDB = 9'h120;
   localparam logic [8:0] ATT_78_QDB = 9'h138;
   localparam logic [7:0] MIXER_FINE_END = 8'hB8;
   localparam logic [5:0] MIXER_FINE_QUAD = 6'h2E;
   localparam logic [5:0] MIXER_COARSE_LAST = 6'h35;
   localparam logic [5:0] MIXER_Q_63 = 6'h36;
   localparam logic [5:0] MIXER_Q_66 = 6'h37;
   localparam logic [5:0] MIXER_Q_72 = 6'h38;
   localparam logic [8:0] ATT_63_QDB = 9'h0FC;
   localparam logic [8:0] ATT_66_QDB = 9'h108;

endpackage : cpcvr_pkg

// ==== cpcvr_vol_if.sv ====
`timescale 1ns/1ps
`default_nettype none
interface cpcvr_vol_if;
   logic [7:0] code;
   logic [8:0] atten;
   logic mute;
   modport ctrl (output code, input atten, input mute);
   modport dec (input code, output atten, output mute);
endinterface : cpcvr_vol_if
`default_nettype wire

// ==== cpcvr_vol_dec.sv ====
`timescale 1ns/1ps
`default_nettype none
module cpcvr_vol_dec #(
   parameter bit IS_MIXER = 1'b0
) (
   input wire logic core_clk_in,
   input wire logic rst_in,
   cpcvr_vol_if.dec vol
);

   typedef struct packed {
      logic [8:0] atten;
      logic mute;
   } cpcvr_dec_s;

   cpcvr_dec_s st_ff;
   cpcvr_dec_s nxt_st;
   logic [5:0] quad;

   assign quad = vol.code[7:2];

   // ---------------------------------------------------------------
   // Code to attenuation
   // ---------------------------------------------------------------
   always_comb begin
      nxt_st = st_ff;
      nxt_st.mute = 1'b0;
      if (!IS_MIXER) begin
         if (vol.code <= cpcvr_pkg::MASTER_FINE_END) begin
            nxt_st.atten = {1'b0, vol.code};
         end else if (quad <= cpcvr_pkg::MASTER_COARSE_LAST) begin
            nxt_st.atten = {1'b0, cpcvr_pkg::MASTER_FINE_END}
               + 9'({quad - cpcvr_pkg::MASTER_FINE_QUAD, 3'h0});
         end else if (quad == cpcvr_pkg::MASTER_Q_69) begin
            nxt_st.atten = cpcvr_pkg::ATT_69_QDB;
         end else if (quad == cpcvr_pkg::MASTER_Q_72) begin
            nxt_st.atten = cpcvr_pkg::ATT_72_QDB;
         end else if (quad == cpcvr_pkg::MASTER_Q_78) begin
            nxt_st.atten = cpcvr_pkg::ATT_78_QDB;
         end else begin
            nxt_st.atten = cpcvr_pkg::ATT_78_QDB;
            nxt_st.mute = 1'b1;
         end
      end else begin
         if (vol.code <= cpcvr_pkg::MIXER_FINE_END) begin
            nxt_st.atten = {1'b0, vol.code};
         end else if (quad <= cpcvr_pkg::MIXER_COARSE_LAST) begin
            nxt_st.atten = {1'b0, cpcvr_pkg::MIXER_FINE_END}
               + 9'({quad - cpcvr_pkg::MIXER_FINE_QUAD, 3'h0});
         end else if (quad == cpcvr_pkg::MIXER_Q_63) begin
            nxt_st.atten = cpcvr_pkg::ATT_63_QDB;
         end else if (quad == cpcvr_pkg::MIXER_Q_66) begin
            nxt_st.atten = cpcvr_pkg::ATT_66_QDB;
         end else if (quad == cpcvr_pkg::MIXER_Q_72) begin
            nxt_st.atten = cpcvr_pkg::ATT_72_QDB;
         end else begin
            nxt_st.atten = cpcvr_pkg::ATT_72_QDB;
            nxt_st.mute = 1'b1;
         end
      end
   end

   always_ff @(posedge core_clk_in) begin
      if (rst_in) begin
         st_ff <= '0;
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign vol.atten = st_ff.atten;
   assign vol.mute = st_ff.mute;

endmodule // cpcvr_vol_dec
`default_nettype wire

// ==== cpcvr_top.sv ====
`timescale 1ns/1ps
`default_nettype none
module cpcvr_top (
   input wire logic core_clk_in,
   input wire logic rst_in,
   input wire logic [7:0] reg_addr_in,
   input wire logic [15:0] reg_wdata_in,
   input wire logic reg_wr_in,
   input wire logic reg_rd_in,
   output logic [15:0] reg_rdata_out,
   input wire logic pll_locked_in,
   output logic dac_power_on_out,
   output logic adc_bias_power_on_out,
   output logic adc_left_power_on_out,
   output logic adc_right_power_on_out,
   output logic dac_clock_enable_out,
   output logic interpolator_mute_out,
   output logic decimator_clock_enable_out,
   output logic interpolator_clock_enable_out,
   output logic [7:0] master_volume_left_out,
   output logic [7:0] master_volume_right_out,
   output logic [7:0] mixer_volume_ch1_out,
   output logic [7:0] mixer_volume_ch2_out,
   output logic [8:0] master_atten_left_out,
   output logic [8:0] master_atten_right_out,
   output logic [8:0] mixer_atten_ch1_out,
   output logic [8:0] mixer_atten_ch2_out,
   output logic master_mute_left_out,
   output logic master_mute_right_out,
   output logic mixer_mute_ch1_out,
   output logic mixer_mute_ch2_out
);

   // ---------------------------------------------------------------
   // State
   // ---------------------------------------------------------------
   typedef struct packed {
      logic [15:0] pwr_clk;
      logic [15:0] master_vol;
      logic [15:0] mixer_vol;
      logic [15:0] rdata;
      logic lock_meta;
      logic lock_sync;
      logic adc_left_pwr;
      logic adc_right_pwr;
      logic adc_bias_pwr;
      logic dac_clk_en;
      logic int_mute;
      logic dec_clk_en;
      logic int_clk_en;
   } cpcvr_state_s;

   cpcvr_state_s st_ff;
   cpcvr_state_s nxt_st;
   cpcvr_state_s rst_st;

   logic auto_unlock;
   logic [15:0] rd_mux;

   // ---------------------------------------------------------------
   // Reset image
   // ---------------------------------------------------------------
   always_comb begin
      rst_st = '0;
      rst_st.pwr_clk = cpcvr_pkg::PWR_CLK_RESET;
      rst_st.master_vol = cpcvr_pkg::MASTER_VOL_RESET;
      rst_st.mixer_vol = cpcvr_pkg::MIXER_VOL_RESET;
      rst_st.adc_left_pwr = 1'b1;
      rst_st.adc_right_pwr = 1'b1;
      rst_st.adc_bias_pwr = 1'b1;
      rst_st.dec_clk_en = 1'b1;
      rst_st.int_clk_en = 1'b1;
   end

   // ---------------------------------------------------------------
   // Read mux
   // ---------------------------------------------------------------
   always_comb begin
      rd_mux = 16'h0000;
      unique case (reg_addr_in)
         cpcvr_pkg::PWR_CLK_CTRL_OFFS: begin
            rd_mux = st_ff.pwr_clk & cpcvr_pkg::PWR_CLK_MASK;
         end
         cpcvr_pkg::MASTER_VOL_OFFS: begin
            rd_mux = st_ff.master_vol;
         end
         cpcvr_pkg::MIXER_VOL_OFFS: begin
            rd_mux = st_ff.mixer_vol;
         end
         default: begin
            rd_mux = 16'h0000;
         end
      endcase
   end

   // Unlocked PLL only matters while the auto function is on
   assign auto_unlock = st_ff.pwr_clk[cpcvr_pkg::DAC_CLK_AUTO_BIT]
      & ~st_ff.lock_sync;

   // ---------------------------------------------------------------
   // Next state
   // ---------------------------------------------------------------
   always_comb begin
      nxt_st = st_ff;

      // Two-stage sync of the PLL lock level
      nxt_st.lock_meta = pll_locked_in;
      nxt_st.lock_sync = st_ff.lock_meta;

      // Register writes
      if (reg_wr_in) begin
         unique case (reg_addr_in)
            cpcvr_pkg::PWR_CLK_CTRL_OFFS: begin
               nxt_st.pwr_clk = reg_wdata_in
                  & cpcvr_pkg::PWR_CLK_MASK;
            end
            cpcvr_pkg::MASTER_VOL_OFFS: begin
               nxt_st.master_vol = reg_wdata_in;
            end
            cpcvr_pkg::MIXER_VOL_OFFS: begin
               nxt_st.mixer_vol = reg_wdata_in;
            end
            default: begin
               nxt_st.pwr_clk = st_ff.pwr_clk;
            end
         endcase
      end

      // Read data stands only in cycles after one with reg_rd_in high
      nxt_st.rdata = reg_rd_in ? rd_mux : 16'h0000;

      // ADC power gating by the bias bit
      nxt_st.adc_bias_pwr = st_ff.pwr_clk[cpcvr_pkg::ADC_BIAS_BIT];
      nxt_st.adc_left_pwr = st_ff.pwr_clk[cpcvr_pkg::ADC_BIAS_BIT]
         & st_ff.pwr_clk[cpcvr_pkg::ADC_L_PWR_BIT];
      nxt_st.adc_right_pwr = st_ff.pwr_clk[cpcvr_pkg::ADC_BIAS_BIT]
         & st_ff.pwr_clk[cpcvr_pkg::ADC_R_PWR_BIT];

      // DAC clock with automatic stop on PLL unlock
      nxt_st.dac_clk_en = st_ff.pwr_clk[cpcvr_pkg::DAC_CLK_EN_BIT]
         & ~auto_unlock;
      nxt_st.int_mute = auto_unlock;

      // Decimator and interpolator clocks
      nxt_st.dec_clk_en = st_ff.pwr_clk[cpcvr_pkg::DEC_CLK_EN_BIT];
      nxt_st.int_clk_en = st_ff.pwr_clk[cpcvr_pkg::INT_CLK_EN_BIT];
   end

   always_ff @(posedge core_clk_in) begin
      if (rst_in) begin
         st_ff <= rst_st;
      end else begin
         st_ff <= nxt_st;
      end
   end

   // ---------------------------------------------------------------
   // Volume decoders
   // ---------------------------------------------------------------
   cpcvr_vol_if vif[cpcvr_pkg::NUM_VOL_CH] ();

   assign vif[0].code = st_ff.master_vol[15:8];
   assign vif[1].code = st_ff.master_vol[7:0];
   assign vif[2].code = st_ff.mixer_vol[7:0];
   assign vif[3].code = st_ff.mixer_vol[15:8];

   generate
      for (genvar i = 0; i < cpcvr_pkg::NUM_VOL_CH; i++) begin : g_dec
         cpcvr_vol_dec #(
            .IS_MIXER(i >= 2)
         ) u_dec (
            .core_clk_in(core_clk_in),
            .rst_in(rst_in),
            .vol(vif[i].dec)
         );
      end
   endgenerate

   // ---------------------------------------------------------------
   // Outputs
   // ---------------------------------------------------------------
   assign reg_rdata_out = st_ff.rdata;
   // Straight from the register bit, nothing else mixed in
   assign dac_power_on_out =
      st_ff.pwr_clk[cpcvr_pkg::DAC_PWR_BIT];
   assign adc_bias_power_on_out = st_ff.adc_bias_pwr;
   assign adc_left_power_on_out = st_ff.adc_left_pwr;
   assign adc_right_power_on_out = st_ff.adc_right_pwr;
   assign dac_clock_enable_out = st_ff.dac_clk_en;
   assign interpolator_mute_out = st_ff.int_mute;
   assign decimator_clock_enable_out = st_ff.dec_clk_en;
   assign interpolator_clock_enable_out = st_ff.int_clk_en;
   assign master_volume_left_out = st_ff.master_vol[15:8];
   assign master_volume_right_out = st_ff.master_vol[7:0];
   assign mixer_volume_ch1_out = st_ff.mixer_vol[7:0];
   assign mixer_volume_ch2_out = st_ff.mixer_vol[15:8];
   assign master_atten_left_out = vif[0].atten;
   assign master_atten_right_out = vif[1].atten;
   assign mixer_atten_ch1_out = vif[2].atten;
   assign mixer_atten_ch2_out = vif[3].atten;
   assign master_mute_left_out = vif[0].mute;
   assign master_mute_right_out = vif[1].mute;
   assign mixer_mute_ch1_out = vif[2].mute;
   assign mixer_mute_ch2_out = vif[3].mute;

endmodule // cpcvr_top
`default_nettype wire

// ==== cpcvr_checker.sv ====
`timescale 1ns/1ps
`default_nettype none
module cpcvr_checker (
   input wire logic core_clk_in,
   input wire logic rst_in,
   input wire logic [7:0] reg_addr_in,
   input wire logic [15:0] reg_wdata_in,
   input wire logic reg_wr_in,
   input wire logic reg_rd_in,
   input wire logic [15:0] reg_rdata_out,
   input wire logic dac_power_on_out,
   input wire logic adc_bias_power_on_out,
   input wire logic adc_left_power_on_out,
   input wire logic adc_right_power_on_out,
   input wire logic dac_clock_enable_out,
   input wire logic interpolator_mute_out,
   input wire logic decimator_clock_enable_out,
   input wire logic interpolator_clock_enable_out,
   input wire logic [7:0] master_volume_left_out,
   input wire logic [8:0] master_atten_left_out,
   input wire logic master_mute_left_out
);
   default clocking @(posedge core_clk_in); endclocking
   default disable iff (rst_in);
   logic pwr_wr;
   logic [15:0] wd1;
   logic [15:0] wd2;
   assign pwr_wr = reg_wr_in && reg_addr_in == 8'h04;
   // ---------------------------------------------------------------
   // Write data delayed to line up with outputs
   // ---------------------------------------------------------------
   always_ff @(posedge core_clk_in) begin
      wd1 <= reg_wdata_in;
      wd2 <= wd1;
   end
   a_dac_power: assert property (
      pwr_wr |=> dac_power_on_out == wd1[15]) else $error("dac power");
   a_dac_alone: assert property (
      !pwr_wr |=> $stable(dac_power_on_out)) else $error("dac power moved");
   a_bias_gate: assert property (
      !adc_bias_power_on_out |-> !adc_left_power_on_out
      && !adc_right_power_on_out) else $error("adc powered without bias");
   a_adc_select: assert property (
      pwr_wr |=> ##1 adc_left_power_on_out == (wd2[8] & wd2[10])
      && adc_right_power_on_out == (wd2[8] & wd2[9])) else $error("adc sel");
   a_dac_clock: assert property (
      pwr_wr && !reg_wdata_in[6] |=> ##1 dac_clock_enable_out == wd2[7])
      else $error("dac clock");
   a_auto_off: assert property (
      pwr_wr && !reg_wdata_in[6] |=> ##1 !interpolator_mute_out)
      else $error("mute without auto");
   a_mute_stop: assert property (
      interpolator_mute_out |-> !dac_clock_enable_out)
      else $error("clock runs while muted");
   a_clk_gates: assert property (
      pwr_wr |=> ##1 decimator_clock_enable_out == wd2[2]
      && interpolator_clock_enable_out == wd2[0]) else $error("clk gate");
   a_vol_split: assert property (
      reg_wr_in && reg_addr_in == 8'h10 |=>
      master_volume_left_out == wd1[15:8]) else $error("left volume");
   a_fine_atten: assert property (
      master_volume_left_out <= 8'hD0 |=> master_atten_left_out ==
      {1'b0, $past(master_volume_left_out)}) else $error("fine atten");
   a_mute_code: assert property (
      master_volume_left_out >= 8'hFC |=> master_mute_left_out)
      else $error("no mute");
   a_rsv_zero: assert property (
      reg_rd_in && reg_addr_in == 8'h04 |=>
      (reg_rdata_out & 16'h783A) == 16'h0000) else $error("reserved set");
endmodule // cpcvr_checker
bind cpcvr_top cpcvr_checker chk_u (.*);
`default_nettype wire

// ==== cpcvr_host_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module cpcvr_host_model (
   input wire logic core_clk_in,
   input wire logic [15:0] rdata_in,
   output logic [7:0] addr_out,
   output logic [15:0] wdata_out,
   output logic wr_out,
   output logic rd_out
);
   initial begin
      addr_out = 8'h00;
      wdata_out = 16'h0000;
      wr_out = 1'b0;
      rd_out = 1'b0;
   end
   // ---------------------------------------------------------------
   // Bus cycles; after each cycle the address shows its inverted value, and after a write the data too
   // ---------------------------------------------------------------
   task automatic wr_reg(input logic [7:0] a, input logic [15:0] d);
      @(posedge core_clk_in);
      addr_out <= a;
      wdata_out <= d;
      wr_out <= 1'b1;
      @(posedge core_clk_in);
      wr_out <= 1'b0;
      addr_out <= ~a;
      wdata_out <= ~d;
   endtask
   task automatic rd_reg(input logic [7:0] a, output logic [15:0] d);
      @(posedge core_clk_in);
      addr_out <= a;
      rd_out <= 1'b1;
      @(posedge core_clk_in);
      rd_out <= 1'b0;
      addr_out <= ~a;
      #1;
      d = rdata_in;
   endtask
endmodule // cpcvr_host_model
`default_nettype wire

// ==== tb_codec_power_clock_volume_regs.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb_codec_power_clock_volume_regs;
   logic core_clk_in = 1'b0;
   logic rst_in = 1'b1;
   logic pll_locked_in = 1'b1;
   logic reg_wr_in, reg_rd_in;
   logic [7:0] reg_addr_in, master_volume_left_out, master_volume_right_out;
   logic [7:0] mixer_volume_ch1_out, mixer_volume_ch2_out, pwr_vec;
   logic [15:0] reg_wdata_in, reg_rdata_out, rd;
   logic [8:0] master_atten_left_out, master_atten_right_out;
   logic [8:0] mixer_atten_ch1_out, mixer_atten_ch2_out;
   logic dac_power_on_out, adc_bias_power_on_out, adc_left_power_on_out;
   logic adc_right_power_on_out, dac_clock_enable_out, interpolator_mute_out;
   logic decimator_clock_enable_out, interpolator_clock_enable_out;
   logic master_mute_left_out, master_mute_right_out;
   logic mixer_mute_ch1_out, mixer_mute_ch2_out;
   int fail_count = 0;
   int compares = 0;
   int cyc = 0;
   always #12.5 core_clk_in = ~core_clk_in;
   assign pwr_vec = {dac_power_on_out, adc_bias_power_on_out,
      adc_left_power_on_out, adc_right_power_on_out, dac_clock_enable_out,
      interpolator_mute_out, decimator_clock_enable_out,
      interpolator_clock_enable_out};
   cpcvr_top dut_u (.*);
   cpcvr_host_model host_u (.core_clk_in(core_clk_in),
      .rdata_in(reg_rdata_out), .addr_out(reg_addr_in),
      .wdata_out(reg_wdata_in), .wr_out(reg_wr_in), .rd_out(reg_rd_in));
   // ---------------------------------------------------------------
   // Helpers
   // ---------------------------------------------------------------
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      compares++;
      if (got !== exp) begin
         fail_count++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic settle(input int n);
      repeat (n) @(posedge core_clk_in);
      #1;
   endtask
   task automatic pll(input logic v);
      @(posedge core_clk_in);
      pll_locked_in <= v;
      settle(4);
   endtask
   task automatic end_of_test;
      $display("compares %0d mismatches %0d", compares, fail_count);
      if (fail_count == 0 && compares > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   // ---------------------------------------------------------------
   // Scenarios
   // ---------------------------------------------------------------
   task automatic t_reset;
      host_u.rd_reg(8'h04, rd);
      chk(rd, 16'h8705);
      host_u.rd_reg(8'h10, rd);
      chk(rd, 16'h0000);
      host_u.rd_reg(8'h11, rd);
      chk(rd, 16'hFF00);
      chk(16'(pwr_vec), 16'h00F3);
      chk(16'(mixer_mute_ch2_out), 16'h0001);
      $display("reset test done");
   endtask
   task automatic t_power;
      for (int k = 0; k < 8; k++) begin
         host_u.wr_reg(8'h04, 16'h8005 | 16'(k << 8));
         settle(1);
         chk(16'(pwr_vec[5:4]), 16'({k[0] & k[2], k[0] & k[1]}));
      end
      host_u.wr_reg(8'h04, 16'hFFFF);
      host_u.rd_reg(8'h04, rd);
      chk(rd, 16'h87C5);
      chk(16'(pwr_vec), 16'h00FB);
      host_u.wr_reg(8'h04, 16'h0000);
      settle(1);
      chk(16'(pwr_vec), 16'h0000);
      host_u.wr_reg(8'h04, 16'h80C0);
      pll(1'b0);
      chk(16'(pwr_vec), 16'h0084);
      pll(1'b1);
      chk(16'(pwr_vec), 16'h0088);
      host_u.wr_reg(8'h04, 16'h8080);
      pll(1'b0);
      chk(16'(pwr_vec), 16'h0088);
      pll(1'b1);
      $display("power test done");
   endtask
   task automatic t_vol;
      logic [7:0] mc [9] = '{8'h00, 8'h01, 8'hD0, 8'hD3, 8'hD4, 8'hEC,
         8'hF0, 8'hF4, 8'hF8};
      logic [8:0] ma [9] = '{9'h000, 9'h001, 9'h0D0, 9'h0D0, 9'h0D8,
         9'h108, 9'h114, 9'h120, 9'h138};
      logic [7:0] xc [4] = '{8'h00, 8'hB8, 8'hD8, 8'hE0};
      logic [8:0] xa [4] = '{9'h000, 9'h0B8, 9'h0FC, 9'h120};
      for (int k = 0; k < 9; k++) begin
         host_u.wr_reg(8'h10, {mc[k], mc[k]});
         settle(1);
         chk(16'(master_atten_left_out), 16'(ma[k]));
         chk(16'(master_atten_right_out), 16'(ma[k]));
      end
      host_u.wr_reg(8'h10, 16'hFCFC);
      settle(1);
      chk(16'({master_mute_left_out, master_mute_right_out}), 16'h0003);
      host_u.wr_reg(8'h10, 16'hA512);
      host_u.rd_reg(8'h10, rd);
      chk(rd, 16'hA512);
      chk({master_volume_left_out, master_volume_right_out}, 16'hA512);
      for (int k = 0; k < 4; k++) begin
         host_u.wr_reg(8'h11, {xc[k], xc[k]});
         settle(1);
         chk(16'(mixer_atten_ch1_out), 16'(xa[k]));
         chk(16'(mixer_atten_ch2_out), 16'(xa[k]));
      end
      host_u.wr_reg(8'h11, 16'hE4E4);
      settle(1);
      chk(16'({mixer_mute_ch1_out, mixer_mute_ch2_out}), 16'h0003);
      host_u.wr_reg(8'h11, 16'h3C5A);
      host_u.rd_reg(8'h11, rd);
      chk(rd, 16'h3C5A);
      chk({mixer_volume_ch2_out, mixer_volume_ch1_out}, 16'h3C5A);
      $display("volume test done");
   endtask
   task automatic t_unmapped;
      host_u.wr_reg(8'h05, 16'hFFFF);
      host_u.rd_reg(8'h05, rd);
      chk(rd, 16'h0000);
      host_u.rd_reg(8'h04, rd);
      chk(rd, 16'h8080);
      $display("unmapped test done");
   endtask
   // ---------------------------------------------------------------
   // Sequence and timeout
   // ---------------------------------------------------------------
   always @(posedge core_clk_in) begin
      cyc++;
      if (cyc == 2000) begin
         fail_count++;
         end_of_test();
      end
   end
   initial begin
      repeat (3) @(posedge core_clk_in);
      rst_in <= 1'b0;
      t_reset();
      t_power();
      t_vol();
      t_unmapped();
      end_of_test();
   end
endmodule // tb_codec_power_clock_volume_regs
`default_nettype wire
